// ---- src/pulse_src_map.svh ----
// register map and field constants of the pulse output source selection
`ifndef PULSE_SRC_MAP_SVH
`define PULSE_SRC_MAP_SVH

// byte offsets of the apb registers
`define CFG_MODE_OFFSET      12'h000
`define COMP_MODE_OFFSET     12'h004
`define STATUS_OFFSET        12'h008

// field positions of the cfg mode register
`define FIRST_SEL_LSB        0
`define SECOND_SEL_LSB       3
`define THIRD_SEL_LSB        6
`define FIRST_DIS_BIT        9

// field positions of the computation mode register
`define FIRST_PHASE_LSB      0
`define SECOND_PHASE_LSB     3
`define THIRD_PHASE_LSB      6

// reset values
`define CFG_MODE_RESET       32'h0000_0288
`define COMP_MODE_RESET      32'h0000_01ff
`define SOURCE_VALID_RESET   3'h7

`endif

// ---- src/pulse_src_pkg.sv ----
// types of the pulse output source selection
package pulse_src_pkg;

    // power quantity codes of a source-select field
    typedef enum logic [2:0] {
        SRC_TOTAL_ACTIVE   = 3'h0,
        SRC_TOTAL_REACTIVE = 3'h1,
        SRC_APPARENT       = 3'h2,
        SRC_FUND_ACTIVE    = 3'h3,
        SRC_FUND_REACTIVE  = 3'h4
    } source_code_t;

    // per-phase powers, one signed word per phase
    typedef struct packed {
        logic signed [23:0] ph_c;
        logic signed [23:0] ph_b;
        logic signed [23:0] ph_a;
    } phase_power_t;

    // all five quantities of all three phases
    typedef struct packed {
        phase_power_t fund_reactive;
        phase_power_t fund_active;
        phase_power_t apparent;
        phase_power_t total_reactive;
        phase_power_t total_active;
    } power_set_t;

endpackage : pulse_src_pkg

// ---- src/pulse_output_source_select.sv ----
// selects the power quantity that drives each of the three pulse outputs
//
// Contract
// [R1] second_source_select is cfg bits 5:3, resets to 001, and 001 selects summed total reactive power.
// [R2] second output code 010 selects summed apparent power.
// [R3] second output code 011 selects summed fundamental active power.
// [R4] second output code 100 selects summed fundamental reactive power.
// [R5] second output reserved codes 101, 110, 111 stop its pulses.
// [R6] third_source_select is cfg bits 8:6, resets to 010, and 000 selects summed total active power.
// [R7] third output code 001 selects summed total reactive power.
// [R8] third output code 010 selects summed apparent power.
// [R9] third output code 011 selects summed fundamental active power.
// [R10] third output code 100 selects summed fundamental reactive power.
// [R11] only phases flagged in each output's phase-select field contribute; the third uses bits 8:6.
// [R12] first output reserved codes 101, 110, 111 stop its pulses.
// [R13] first_output_disable is cfg bit 9, resets to 1, and holds the first pulse output inactive.
// [R14] while disabled the first converter keeps accumulating.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_src_map.svh"

module pulse_output_source_select
    import pulse_src_pkg::*;
#(
    parameter int ACC_WIDTH   = 32,
    parameter int PULSE_WIDTH = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire power_set_t  powers,
    input  wire logic [ACC_WIDTH-1:0] dfc_threshold,
    output logic             pulse_out_first,
    output logic             pulse_out_second,
    output logic             pulse_out_third,
    output logic      [2:0]  source_valid
);

    localparam int SUM_W = 26;

    // configuration and status registers
    logic [9:0]  cfg_mode_ff;
    logic [8:0]  computation_mode_register_ff;
    logic [2:0]  pulse_seen_ff;
    // field views
    logic [2:0]  first_source_select;
    logic [2:0]  second_source_select;
    logic [2:0]  third_source_select;
    logic        first_output_disable;
    logic [2:0]  first_phase_select;
    logic [2:0]  second_phase_select;
    logic [2:0]  third_phase_select;
    // bus decode
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    // converter sums and handshakes
    logic signed [SUM_W-1:0] sum_first;
    logic signed [SUM_W-1:0] sum_second;
    logic signed [SUM_W-1:0] sum_third;
    logic [2:0]  run;
    logic [2:0]  fire;
    logic [2:0]  pulse_raw;
    // next values of the registered outputs
    logic [9:0]  nxt_cfg_mode;
    logic [31:0] nxt_prdata;
    logic [31:0] prdata_ff;
    logic [2:0]  source_valid_ff;

    // field views of the configuration registers
    assign first_source_select  = cfg_mode_ff[`FIRST_SEL_LSB +: 3];
    assign second_source_select = cfg_mode_ff[`SECOND_SEL_LSB +: 3];          // R1
    assign third_source_select  = cfg_mode_ff[`THIRD_SEL_LSB +: 3];           // R6
    assign first_output_disable = cfg_mode_ff[`FIRST_DIS_BIT];                // R13
    assign first_phase_select   = computation_mode_register_ff[`FIRST_PHASE_LSB +: 3];
    assign second_phase_select  = computation_mode_register_ff[`SECOND_PHASE_LSB +: 3];
    assign third_phase_select   = computation_mode_register_ff[`THIRD_PHASE_LSB +: 3]; // R11

    // apb decode, zero wait states; reads are looked up in the setup cycle
    assign addr_ok = (paddr == `CFG_MODE_OFFSET) || (paddr == `COMP_MODE_OFFSET) || (paddr == `STATUS_OFFSET);
    assign wr_en   = psel && penable && pwrite && clk_en;
    assign rd_en   = psel && !penable && !pwrite;
    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // sum the chosen quantity over the enabled phases
    function automatic logic signed [SUM_W-1:0] pick_sum(
        input logic [2:0]  code,
        input logic [2:0]  phases,
        input power_set_t  p
    );
        phase_power_t q;
        logic signed [SUM_W-1:0] acc;
        q   = '0;
        acc = '0;
        case (code)
            3'h0:    q = p.total_active;                                      // R6
            3'h1:    q = p.total_reactive;                                    // R1 R7
            3'h2:    q = p.apparent;                                          // R2 R8
            3'h3:    q = p.fund_active;                                       // R3 R9
            3'h4:    q = p.fund_reactive;                                     // R4 R10
            default: q = '0;
        endcase
        // only flagged phases contribute
        if (phases[0]) begin                                                  // R11
            acc = acc + SUM_W'(q.ph_a);
        end
        if (phases[1]) begin
            acc = acc + SUM_W'(q.ph_b);
        end
        if (phases[2]) begin
            acc = acc + SUM_W'(q.ph_c);
        end
        return acc;
    endfunction : pick_sum

    // quantity selection for the first output
    always_comb begin
        sum_first  = pick_sum(first_source_select, first_phase_select, powers);
    end

    // quantity selection for the second output
    always_comb begin
        sum_second = pick_sum(second_source_select, second_phase_select, powers);
    end

    // quantity selection for the third output
    always_comb begin
        sum_third  = pick_sum(third_source_select, third_phase_select, powers);
    end

    // reserved codes stop the converter
    assign run[0] = (first_source_select <= 3'h4);                            // R12
    assign run[1] = (second_source_select <= 3'h4);                           // R5
    assign run[2] = (third_source_select <= 3'h4);                            // R10
    assign source_valid = source_valid_ff;

    // next configuration word; a frozen meter ignores writes
    always_comb begin
        nxt_cfg_mode = cfg_mode_ff;
        if (wr_en && paddr == `CFG_MODE_OFFSET) begin
            nxt_cfg_mode = pwdata[9:0];
        end
    end

    // configuration register, resets to its documented defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_mode_ff <= 10'(`CFG_MODE_RESET);                              // R1 R6 R13
        end else begin
            cfg_mode_ff <= nxt_cfg_mode;
        end
    end

    // registered code check, tracks the configuration word edge for edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_valid_ff <= `SOURCE_VALID_RESET;                           // reset codes are in use
        end else if (clk_en) begin
            source_valid_ff[0] <= (nxt_cfg_mode[`FIRST_SEL_LSB +: 3] <= 3'h4);   // R12
            source_valid_ff[1] <= (nxt_cfg_mode[`SECOND_SEL_LSB +: 3] <= 3'h4);  // R5
            source_valid_ff[2] <= (nxt_cfg_mode[`THIRD_SEL_LSB +: 3] <= 3'h4);
        end
    end

    // phase-select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            computation_mode_register_ff <= 9'(`COMP_MODE_RESET);
        end else if (wr_en && paddr == `COMP_MODE_OFFSET) begin
            computation_mode_register_ff <= pwdata[8:0];
        end
    end

    // sticky record of converter overflows, cleared by writing ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_seen_ff <= 3'h0;
        end else if (clk_en) begin
            if (wr_en && paddr == `STATUS_OFFSET) begin
                pulse_seen_ff <= (pulse_seen_ff & ~pwdata[2:0]) | fire;
            end else begin
                pulse_seen_ff <= pulse_seen_ff | fire;
            end
        end
    end

    // read lookup in the setup cycle, zero otherwise
    always_comb begin
        nxt_prdata = 32'h0;
        if (rd_en) begin
            case (paddr)
                `CFG_MODE_OFFSET:  nxt_prdata = {22'h0, cfg_mode_ff};
                `COMP_MODE_OFFSET: nxt_prdata = {23'h0, computation_mode_register_ff};
                `STATUS_OFFSET:    nxt_prdata = {26'h0, source_valid_ff, pulse_seen_ff};
                default:           nxt_prdata = 32'h0;
            endcase
        end
    end

    // read data register, stands through the access cycle then drops to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else begin
            prdata_ff <= nxt_prdata;                                          // bus answers while frozen
        end
    end

    // one converter per output; each runs regardless of the gate
    dfc_channel #(
        .ACC_WIDTH   (ACC_WIDTH),
        .SUM_W       (SUM_W),
        .PULSE_WIDTH (PULSE_WIDTH)
    ) u_dfc_first (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .run       (run[0]),                                                  // R14
        .power     (sum_first),
        .threshold (dfc_threshold),
        .fire      (fire[0]),
        .pulse     (pulse_raw[0])
    );

    // converter of the second output
    dfc_channel #(
        .ACC_WIDTH   (ACC_WIDTH),
        .SUM_W       (SUM_W),
        .PULSE_WIDTH (PULSE_WIDTH)
    ) u_dfc_second (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .run       (run[1]),
        .power     (sum_second),
        .threshold (dfc_threshold),
        .fire      (fire[1]),
        .pulse     (pulse_raw[1])
    );

    // converter of the third output
    dfc_channel #(
        .ACC_WIDTH   (ACC_WIDTH),
        .SUM_W       (SUM_W),
        .PULSE_WIDTH (PULSE_WIDTH)
    ) u_dfc_third (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .run       (run[2]),
        .power     (sum_third),
        .threshold (dfc_threshold),
        .fire      (fire[2]),
        .pulse     (pulse_raw[2])
    );

    // output gating; the first output is blanked only, never reset
    // blanking sits after the stretcher, so the converter never sees it
    // a pulse cut by blanking is not replayed when the gate opens
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_out_first  <= 1'b0;
            pulse_out_second <= 1'b0;
            pulse_out_third  <= 1'b0;
        end else if (clk_en) begin
            pulse_out_first  <= pulse_raw[0] && !first_output_disable;        // R13
            pulse_out_second <= pulse_raw[1];
            pulse_out_third  <= pulse_raw[2];
        end
    end

endmodule : pulse_output_source_select

// converter notes:
// accumulator sheds one quantum per pulse, and wraps at ACC_WIDTH bits once a growing remainder passes the top
// a quantum below the largest magnitude lets the remainder grow
// a zero quantum leaves the accumulator running with no pulses at all
// the stretch counter retriggers, so dense pulses merge into one
// a reserved code freezes the remainder until a valid code returns

// digital-to-frequency converter: accumulates |power| and emits a pulse per threshold
module dfc_channel #(
    parameter int ACC_WIDTH   = 32,
    parameter int SUM_W       = 26,
    parameter int PULSE_WIDTH = 4
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    clk_en,
    input  wire logic                    run,
    input  wire logic signed [SUM_W-1:0] power,
    input  wire logic [ACC_WIDTH-1:0]    threshold,
    output logic                         fire,
    output logic                         pulse
);

    logic [ACC_WIDTH-1:0] acc_ff;
    logic [ACC_WIDTH-1:0] nxt_acc;
    logic [7:0]           width_ff;
    logic [SUM_W-1:0]     mag;

    // magnitude of the selected power
    assign mag     = power[SUM_W-1] ? SUM_W'(-power) : SUM_W'(power);
    assign nxt_acc = acc_ff + ACC_WIDTH'(mag);
    assign fire    = run && clk_en && (nxt_acc >= threshold) && (threshold != '0);

    // accumulator, cleared of one quantum on each pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff <= '0;
        end else if (clk_en && run) begin
            acc_ff <= fire ? nxt_acc - threshold : nxt_acc;
        end
    end

    // stretch each event to a visible pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_ff <= 8'h0;
        end else if (clk_en) begin
            if (fire) begin
                width_ff <= 8'(PULSE_WIDTH);
            end else if (width_ff != 8'h0) begin
                width_ff <= width_ff - 8'h1;
            end
        end
    end

    assign pulse = (width_ff != 8'h0);

endmodule : dfc_channel
`default_nettype wire

// ---- verification/pulse_lamp.sv ----
// lamp model that counts the flashes of one pulse output
`timescale 1ns/100ps
`default_nettype none
module pulse_lamp (
    input  wire logic        pclk,
    input  wire logic        clear,
    input  wire logic        pulse,
    output logic      [15:0] flashes
);
    logic        lit_ff;
    logic [15:0] count_ff;
    assign flashes = count_ff;
    // count each switch-on of the lamp
    always_ff @(posedge pclk) begin
        lit_ff <= pulse;
        if (clear) begin
            count_ff <= 16'h0;
        end else if (pulse && !lit_ff) begin
            count_ff <= count_ff + 16'h1;
        end
    end
endmodule : pulse_lamp
`default_nettype wire

// ---- verification/pulse_src_checker.sv ----
// port assertions of the pulse output source selection
`timescale 1ns/100ps
`default_nettype none
module pulse_src_checker #(
    parameter int ACC_WIDTH = 32
) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 clk_en,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [ACC_WIDTH-1:0] dfc_threshold,
    input wire logic                 pulse_out_first,
    input wire logic                 pulse_out_second,
    input wire logic                 pulse_out_third,
    input wire logic [2:0]           source_valid
);
    logic [9:0] cfg_ff;
    // shadow of the source-select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= 10'h288;
        end else if (psel && penable && pwrite && clk_en && paddr == 12'h000) begin
            cfg_ff <= pwdata[9:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_valid_codes: assert property (
        source_valid == {cfg_ff[8:6] < 3'h5, cfg_ff[5:3] < 3'h5, cfg_ff[2:0] < 3'h5})
        else $error("source_valid disagrees with codes");
    a_cfg_readback: assert property (
        psel && penable && !pwrite && paddr == 12'h000 |-> prdata == {22'h0, cfg_ff})
        else $error("cfg read data wrong");
    a_ready_always: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    a_unmapped_error: assert property (psel && penable && paddr > 12'h008 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_second_silent: assert property (
        (clk_en && !source_valid[1]) [*8] |-> !pulse_out_second)
        else $error("second output pulses on reserved code");
    a_third_silent: assert property ((clk_en && !source_valid[2]) [*8] |-> !pulse_out_third)
        else $error("third output pulses on reserved code");
    a_first_silent: assert property (
        (clk_en && !source_valid[0]) [*8] |-> !pulse_out_first)
        else $error("first output pulses on reserved code");
    a_first_blanked: assert property (cfg_ff[9] [*3] |-> !pulse_out_first)
        else $error("first output pulses while disabled");
    a_pulse_width: assert property ($rose(pulse_out_second) |-> pulse_out_second [*4])
        else $error("second pulse too short");
    a_zero_quantum: assert property ((dfc_threshold == '0) [*8] |-> !pulse_out_third)
        else $error("pulses with zero quantum");
endmodule : pulse_src_checker
bind pulse_output_source_select pulse_src_checker #(.ACC_WIDTH(ACC_WIDTH)) checker_u (.pclk, .presetn,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dfc_threshold,
    .pulse_out_first, .pulse_out_second, .pulse_out_third, .source_valid);
`default_nettype wire

// ---- verification/pulse_output_source_select_bench.sv ----
// self-checking bench of the pulse output source selection
`timescale 1ns/100ps
`default_nettype none
module pulse_output_source_select_bench
    import pulse_src_pkg::*;
;
    localparam int T = 2000;
    localparam int W = 600;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, clear;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, dfc_threshold, cfg, ph;
    logic [2:0]  pulse, source_valid;
    logic [15:0] cnt [3];
    power_set_t  powers, p;
    int          num_errors, tests_run, e;

    pulse_output_source_select dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .powers, .dfc_threshold, .pulse_out_first(pulse[0]),
        .pulse_out_second(pulse[1]), .pulse_out_third(pulse[2]), .source_valid);
    // one lamp on each pulse output
    for (genvar i = 0; i < 3; i++) begin : g_lamp
        pulse_lamp lamp (.pclk, .clear, .pulse(pulse[i]), .flashes(cnt[i]));
    end

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // one apb transfer, read data left in rd
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        check(pslverr, a > 12'h008);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            num_errors++;
            report_and_stop();
        end
        @(posedge pclk);
    endtask : acc

    // pulses expected in the window for one code and phase mask
    function automatic int expect_cnt(input logic [2:0] code, input logic [2:0] m);
        phase_power_t q;
        int s;
        if (code > 3'h4) return 0;
        q = powers[72*code +: 72];
        s = (m[0] ? int'(q.ph_a) : 0) + (m[1] ? int'(q.ph_b) : 0) + (m[2] ? int'(q.ph_c) : 0);
        return (s < 0 ? -s : s) * W / T;
    endfunction : expect_cnt

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, dfc_threshold} = '0;
        {powers, num_errors, tests_run} = '0;
        clk_en = 1'b1;
        clear = 1'b1;
        void'($urandom(32'h0d02));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, blocked write, unmapped place
        clk_en <= 1'b0;
        acc(1'b1, 12'h000, 32'h0);
        clk_en <= 1'b1;
        acc(1'b0, 12'h000, 32'h0);
        check(rd, 32'h288);
        acc(1'b0, 12'h004, 32'h0);
        check(rd, 32'h1ff);
        acc(1'b1, 12'h00c, 32'hffff_ffff);
        acc(1'b0, 12'h00c, 32'h0);
        check(rd, 32'h0);
        dfc_threshold <= T;
        // every code on every output, random powers and phases
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 15; k++) p[24*k +: 24] = 24'($urandom_range(120)) - 24'h3c;
            powers <= p;
            cfg = {22'h0, i[0], 3'(i + 1), 3'(i), 3'(i)};
            ph = $urandom_range(511);
            acc(1'b1, 12'h000, cfg);
            acc(1'b1, 12'h004, ph);
            repeat (10) @(posedge pclk);
            clear <= 1'b1;
            acc(1'b1, 12'h008, 32'h7);
            clear <= 1'b0;
            repeat (W) @(posedge pclk);
            for (int k = 0; k < 3; k++) begin
                e = expect_cnt(cfg[3*k +: 3], ph[3*k +: 3]);
                if (cfg[3*k +: 3] > 3'h4 || (k == 0 && cfg[9])) check(cnt[k], 16'h0);
                else check(cnt[k] + 1 >= e && cnt[k] <= e + 2, 32'h1);
            end
            acc(1'b0, 12'h008, 32'h0);
            check(rd[5:3], {cfg[8:6] < 3'h5, cfg[5:3] < 3'h5, cfg[2:0] < 3'h5});
            if (expect_cnt(cfg[2:0], ph[2:0]) > 2) check(rd[0], 1'b1);
        end
        report_and_stop();
    end
endmodule : pulse_output_source_select_bench
`default_nettype wire
